// ---- dv/pci_power_mgmt_capability_tb.sv ----
// Self-checking bench for the power management capability bank.
// Assumes the host model in ppmc_host.sv drives the register port.
`timescale 1ns/1ps
module pci_power_mgmt_capability_tb;
   localparam logic [31:0] PMC_DEF = 32'h0001E401; // Capabilities word after reset.
   logic        core_clk   = 1'b0;
   logic        srst       = 1'b1;
   logic        wake_event = 1'b0;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [1:0]  power_state;
   logic        wake_req;
   int          errors   = 0;
   int          n_checks = 0;

   // Clock of 25 ns.
   initial forever #12.5 core_clk = ~core_clk;

   ppmc_top i_dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .wake_event(wake_event), .power_state(power_state), .wake_req(wake_req));
   ppmc_host i_host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

   // ------------------------------
   // Helpers
   // ------------------------------
   // Compare one value and count it.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Read a word and compare it.
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      i_host.rd(a, v);
      chk(v, exp);
   endtask
   // Check the two status outputs together.
   task automatic outs(input logic [1:0] ps, input logic req);
      chk({29'h0, power_state, wake_req}, {29'h0, ps, req});
   endtask
   task automatic wrap_up;
      if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Watchdog: the tests need well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge core_clk);
      errors++;
      wrap_up();
   end

   // ------------------------------
   // Tests
   // ------------------------------
   initial begin
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      #1;
      outs(2'h0, 1'b0);
      rdchk(8'h34, 32'h000000DC);
      rdchk(8'hDC, PMC_DEF);
      rdchk(8'hE0, 32'h0);
      rdchk(8'h40, 32'h0);
      i_host.wr(8'hDC, 32'hFFFFFFFF);
      rdchk(8'hDC, 32'h482FE401);
      i_host.wr(8'hDC, 32'h08010000);
      rdchk(8'hDC, 32'h0809E401);
      i_host.wr(8'hDC, 32'h0);
      rdchk(8'hDC, 32'h0000E401);
      i_host.wr(8'hE0, 32'h00FF0003);
      rdchk(8'hE0, 32'h3);
      // Unimplemented encodings must leave D3hot in place.
      for (int c = 1; c < 3; c++) begin
         i_host.wr(8'hE0, 32'(c));
         rdchk(8'hE0, 32'h3);
      end
      // An unimplemented state still completes: the enable bit lands.
      i_host.wr(8'hE0, 32'h101);
      rdchk(8'hE0, 32'h103);
      outs(2'h3, 1'b0);
      i_host.wr(8'hE0, 32'h0);
      #1;
      outs(2'h0, 1'b0);
      @(posedge core_clk);
      wake_event <= 1'b1;
      @(posedge core_clk);
      wake_event <= 1'b0;
      rdchk(8'hE0, 32'h8000);
      outs(2'h0, 1'b0);
      i_host.wr(8'hE0, 32'h100);
      #1;
      outs(2'h0, 1'b1);
      i_host.wr(8'hE0, 32'h8100);
      rdchk(8'hE0, 32'h100);
      outs(2'h0, 1'b0);
      i_host.wr(8'hF0, 32'h1);
      rdchk(8'hE0, 32'h8100);
      outs(2'h0, 1'b1);
      i_host.wr(8'hE0, 32'h0);
      rdchk(8'hE0, 32'h8000);
      outs(2'h0, 1'b0);
      // An event in the cycle of a clearing write must leave the status set.
      fork
         i_host.wr(8'hE0, 32'h8000);
         begin
            @(posedge core_clk);
            wake_event <= 1'b1;
            @(posedge core_clk);
            wake_event <= 1'b0;
         end
      join
      rdchk(8'hE0, 32'h8000);
      i_host.wr(8'hE0, 32'h8000);
      rdchk(8'hE0, 32'h0);
      // A second reset in mid-run must restore every field.
      i_host.wr(8'hE0, 32'h103);
      i_host.wr(8'hDC, 32'hFFFFFFFF);
      @(posedge core_clk);
      srst <= 1'b1;
      @(posedge core_clk);
      srst <= 1'b0;
      #1;
      outs(2'h0, 1'b0);
      rdchk(8'hDC, PMC_DEF);
      rdchk(8'hE0, 32'h0);
      wrap_up();
   end
endmodule

// ---- dv/ppmc_host.sv ----
// Host model that issues configuration reads and writes on the register port.
// Assumes one-cycle strobes and read data in the cycle after the read strobe.
`timescale 1ns/1ps
module ppmc_host (
   input  wire logic        core_clk,  // System clock.
   input  wire logic [31:0] reg_rdata, // Read data from the bank.
   output logic      [7:0]  reg_addr,  // Byte address.
   output logic      [31:0] reg_wdata, // Write data.
   output logic             reg_wr,    // Write strobe.
   output logic             reg_rd     // Read strobe.
);
   // ------------------------------
   // Idle bus
   // ------------------------------
   // Idle strobes are low; address and data start at an arbitrary pattern.
   initial begin
      reg_addr  = 8'hA5;
      reg_wdata = 32'h5A5A5A5A;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // host sets state
   // A released bus shows the inverse of the last value, so stale data never looks valid.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask

   // host reads state
   // Data are taken just after the edge that accepted the strobe, once they have settled.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask
endmodule

// ---- hdl/ppmc_pkg.sv ----
// Constants for the power management capability register bank.
// Assumes a byte-addressed configuration port of whole words; offsets are byte addresses.
package ppmc_pkg;

   // ----------------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] CAP_PTR_OFF   = 8'h34;  // Capabilities pointer word.
   localparam logic [7:0] PMC_OFF       = 8'hDC;  // Capabilities word.
   localparam logic [7:0] PMCS_OFF      = 8'hE0;  // Control and status word.
   localparam logic [7:0] EVT_OFF       = 8'hF0;  // Local wake event trigger.

   // ----------------------------------------------------------------------
   // Fixed field values
   // ----------------------------------------------------------------------
   localparam logic [7:0] CAP_LIST_PTR  = 8'hDC;
   localparam logic [7:0] CAPABILITY_IDENTIFIER_VAL    = 8'h01;
   localparam logic [7:0] NEXT_PTR_VAL  = 8'hE4;
   localparam logic [7:0] BSE_VAL       = 8'h00;
   localparam logic [2:0] VER_RST       = 3'h1;
   localparam logic [4:0] WAKE_SUP_RST  = 5'h00;
   localparam logic [4:0] WAKE_SUP_MSK  = 5'h09;  // Only bits 3 and 0 may be set.

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int WAKE_SUP_LSB = 27;
   localparam int D2_BIT       = 26;
   localparam int D1_BIT       = 25;
   localparam int DSI_BIT      = 21;
   localparam int APS_BIT      = 20;
   localparam int CLK_BIT      = 19;
   localparam int VER_LSB      = 16;
   localparam int ST_BIT       = 15;
   localparam int EN_BIT       = 8;
   localparam int PS_LSB       = 0;

   // ----------------------------------------------------------------------
   // Power state encodings
   // ----------------------------------------------------------------------
   localparam logic [1:0] PS_D0    = 2'h0;
   localparam logic [1:0] PS_D3HOT = 2'h3;

endpackage

// ---- hdl/ppmc_top.sv ----
// Power management capability register bank of a bus bridge.
// Assumes a single-cycle register port with read data one cycle later.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module ppmc_top (
   input  wire logic        core_clk,   // 40 MHz clock.
   input  wire logic        srst,       // Bus reset, synchronous, active high.
   input  wire logic [7:0]  reg_addr,   // Byte address of the word.
   input  wire logic [31:0] reg_wdata,  // Write data.
   input  wire logic        reg_wr,     // Write strobe.
   input  wire logic        reg_rd,     // Read strobe.
   output logic      [31:0] reg_rdata,  // Read data, one cycle after strobe.
   input  wire logic        wake_event, // Wake event pulse from core logic.
   output logic      [1:0]  power_state,// Current power state.
   output logic             wake_req    // Gated wake request.
);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   logic [4:0]  wake_support_mask_reg;
   logic        dsi_reg;
   logic [2:0]  power_mgmt_version_reg;
   logic        wake_enable_reg;
   logic [1:0]  power_state_field_reg;
   logic [31:0] rdata_reg;
   logic        wake_status;

   // Address hits, shared by the write strobes, the read mux and the checks.
   logic        hit_pmc;
   logic        hit_pmcs;
   logic        hit_cap;
   logic        hit_evt;

   // Decode of the write strobes.
   logic        wr_pmc;
   logic        wr_pmcs;
   logic        wr_evt;
   logic        ps_ok;
   logic        clear_st;
   logic        wake_trig;
   logic        wake_clock_needed;
   logic [1:0]  ps_wdata;
   logic [31:0] pmc_word;
   logic [31:0] pmcs_word;
   logic [31:0] rd_mux;

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   // One compare serves every path, so a moved offset cannot leave the read
   // mux and the write strobes decoding different words.
   function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
      return addr == offset;
   endfunction

   // Word selects from the byte address; only whole words are decoded.
   assign hit_pmc  = addr_is(reg_addr, ppmc_pkg::PMC_OFF);
   assign hit_pmcs = addr_is(reg_addr, ppmc_pkg::PMCS_OFF);
   assign hit_cap  = addr_is(reg_addr, ppmc_pkg::CAP_PTR_OFF);
   assign hit_evt  = addr_is(reg_addr, ppmc_pkg::EVT_OFF);

   // Write strobes and the fields that they carry.
   assign wr_pmc   = reg_wr && hit_pmc;
   assign wr_pmcs  = reg_wr && hit_pmcs;
   assign wr_evt   = reg_wr && hit_evt;
   assign ps_wdata = reg_wdata[ppmc_pkg::PS_LSB +: 2];
   // filter unimplemented states
   // A write of 01 or 10 still lands its enable and clear bits; only the
   // state field is held, so the host sees a normal completion.
   assign ps_ok    = (ps_wdata == ppmc_pkg::PS_D0) || (ps_wdata == ppmc_pkg::PS_D3HOT);
   assign clear_st = wr_pmcs && reg_wdata[ppmc_pkg::ST_BIT];
   assign wake_clock_needed = |wake_support_mask_reg;
   // A software trigger word shares the event path so tests can raise wakes.
   assign wake_trig = wake_event | (wr_evt & reg_wdata[0]);

   // ----------------------------------------------------------------------
   // Writable fields
   // ----------------------------------------------------------------------
   // Local firmware may load the support and version fields through the
   // capabilities word; a host driver is expected to leave them alone.
   // reset all fields
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wake_support_mask_reg  <= ppmc_pkg::WAKE_SUP_RST;
         dsi_reg                <= 1'b0;
         power_mgmt_version_reg <= ppmc_pkg::VER_RST;
      end else if (wr_pmc) begin
         wake_support_mask_reg  <= reg_wdata[ppmc_pkg::WAKE_SUP_LSB +: 5]
                                   & ppmc_pkg::WAKE_SUP_MSK;
         dsi_reg                <= reg_wdata[ppmc_pkg::DSI_BIT];
         power_mgmt_version_reg <= reg_wdata[ppmc_pkg::VER_LSB +: 3];
      end
   end

   // Control fields of the status word.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wake_enable_reg       <= 1'b0;
         power_state_field_reg <= ppmc_pkg::PS_D0;
      end else if (wr_pmcs) begin
         wake_enable_reg <= reg_wdata[ppmc_pkg::EN_BIT];
         if (ps_ok) begin
            power_state_field_reg <= ps_wdata;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Wake logic
   // ----------------------------------------------------------------------
   // Status and request sit in their own module beside their checks.
   ppmc_wake u_wake (
      .core_clk    (core_clk),
      .srst        (srst),
      .wake_event  (wake_trig),
      .clear_st    (clear_st),
      .wake_enable (wake_enable_reg),
      .wake_status (wake_status),
      .wake_req    (wake_req)
   );

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   // Read-only constants are built here, never stored, so writes cannot
   // reach them.
   // D2 zero
   assign pmc_word = {wake_support_mask_reg, 1'b0, 1'b0, 3'h0, dsi_reg, 1'b0,
                      wake_clock_needed, power_mgmt_version_reg,
                      ppmc_pkg::NEXT_PTR_VAL, ppmc_pkg::CAPABILITY_IDENTIFIER_VAL};
   assign pmcs_word = {8'h00, ppmc_pkg::BSE_VAL, wake_status, 6'h00, wake_enable_reg,
                       6'h00, power_state_field_reg};

   assign rd_mux = hit_pmc  ? pmc_word :
                   hit_pmcs ? pmcs_word :
                   hit_cap  ? {24'h000000, ppmc_pkg::CAP_LIST_PTR} :
                   32'h00000000;

   // Data is held only for the cycle after the strobe; zero otherwise.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdata_reg <= 32'h00000000;
      end else if (reg_rd) begin
         rdata_reg <= rd_mux;
      end else begin
         rdata_reg <= 32'h00000000;
      end
   end

   assign reg_rdata   = rdata_reg;
   assign power_state = power_state_field_reg;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   // Helper views of the write data, so the properties sample plain signals.
   logic [4:0]  mask_wdata;
   logic        en_wdata;

   assign mask_wdata = reg_wdata[ppmc_pkg::WAKE_SUP_LSB +: 5];
   assign en_wdata   = reg_wdata[ppmc_pkg::EN_BIT];

   // A read strobe on each word that the read mux returns.
   sequence s_pmc_read;
      reg_rd && hit_pmc;
   endsequence

   sequence s_pmcs_read;
      reg_rd && hit_pmcs;
   endsequence

   sequence s_cap_read;
      reg_rd && hit_cap;
   endsequence

   // A write strobe on the capabilities word and on the control and status word.
   sequence s_pmc_write;
      wr_pmc;
   endsequence

   sequence s_pmcs_write;
      wr_pmcs;
   endsequence

   property p_mask_bits;
      @(posedge core_clk) disable iff (srst)
         (wake_support_mask_reg & ~ppmc_pkg::WAKE_SUP_MSK) == 5'h00;
   endproperty
   a_mask_bits: assert property (p_mask_bits) else $error("bad mask bits");

   property p_mask_legal;
      @(posedge core_clk) disable iff (srst)
         s_pmc_write |=> wake_support_mask_reg == ($past(mask_wdata) & 5'h09);
   endproperty
   a_mask_legal: assert property (p_mask_legal) else $error("mask write wrong");

   property p_clk_bit;
      @(posedge core_clk) disable iff (srst)
         s_pmc_read |=> reg_rdata[ppmc_pkg::CLK_BIT] == (|reg_rdata[31:27]);
   endproperty
   a_clk_bit: assert property (p_clk_bit) else $error("clock bit wrong");

   property p_pmc_const;
      @(posedge core_clk) disable iff (srst)
         s_pmc_read |=> reg_rdata[15:0] == 16'hE401 && reg_rdata[26:25] == 2'h0
                        && !reg_rdata[ppmc_pkg::APS_BIT];
   endproperty
   a_pmc_const: assert property (p_pmc_const) else $error("constant field wrong");

   property p_d2_zero;
      @(posedge core_clk) disable iff (srst)
         s_pmc_read |=> !reg_rdata[ppmc_pkg::D2_BIT];
   endproperty
   a_d2_zero: assert property (p_d2_zero) else $error("D2 support set");

   property p_d1_zero;
      @(posedge core_clk) disable iff (srst)
         s_pmc_read |=> !reg_rdata[ppmc_pkg::D1_BIT];
   endproperty
   a_d1_zero: assert property (p_d1_zero) else $error("D1 support set");

   property p_aux_zero;
      @(posedge core_clk) disable iff (srst)
         s_pmc_read |=> !reg_rdata[ppmc_pkg::APS_BIT];
   endproperty
   a_aux_zero: assert property (p_aux_zero) else $error("aux source set");

   property p_ver_read;
      @(posedge core_clk) disable iff (srst)
         s_pmc_read |=> reg_rdata[ppmc_pkg::VER_LSB +: 3] == $past(power_mgmt_version_reg);
   endproperty
   a_ver_read: assert property (p_ver_read) else $error("version read wrong");

   property p_next_ptr;
      @(posedge core_clk) disable iff (srst)
         s_pmc_read |=> reg_rdata[15:8] == 8'hE4;
   endproperty
   a_next_ptr: assert property (p_next_ptr) else $error("next pointer wrong");

   property p_bse;
      @(posedge core_clk) disable iff (srst)
         s_pmcs_read |=> reg_rdata[23:16] == 8'h00;
   endproperty
   a_bse: assert property (p_bse) else $error("extensions not zero");

   property p_st_clear;
      @(posedge core_clk) disable iff (srst)
         clear_st && !wake_trig |=> !wake_status;
   endproperty
   a_st_clear: assert property (p_st_clear) else $error("status not cleared");

   property p_req_off;
      @(posedge core_clk) disable iff (srst)
         !wake_enable_reg |-> !wake_req;
   endproperty
   a_req_off: assert property (p_req_off) else $error("request while disabled");

   property p_en_write;
      @(posedge core_clk) disable iff (srst)
         s_pmcs_write |=> wake_enable_reg == $past(en_wdata);
   endproperty
   a_en_write: assert property (p_en_write) else $error("enable not written");

   property p_ps_write;
      @(posedge core_clk) disable iff (srst)
         wr_pmcs && ps_ok |=> power_state == $past(ps_wdata);
   endproperty
   a_ps_write: assert property (p_ps_write) else $error("state not written");

   property p_ps_read;
      @(posedge core_clk) disable iff (srst)
         s_pmcs_read |=> reg_rdata[1:0] == $past(power_state_field_reg);
   endproperty
   a_ps_read: assert property (p_ps_read) else $error("state read wrong");

   property p_ps_legal;
      @(posedge core_clk) disable iff (srst)
         wr_pmcs && !ps_ok |=> $stable(power_state_field_reg);
   endproperty
   a_ps_legal: assert property (p_ps_legal) else $error("illegal state taken");

   property p_cap_ptr;
      @(posedge core_clk) disable iff (srst)
         s_cap_read |=> reg_rdata == 32'h000000DC;
   endproperty
   a_cap_ptr: assert property (p_cap_ptr) else $error("list pointer wrong");

   property p_reset;
      @(posedge core_clk) srst |=> power_state == 2'h0 && !wake_req
                                  && power_mgmt_version_reg == 3'h1;
   endproperty
   a_reset: assert property (p_reset) else $error("reset value wrong");

   property p_reset_full;
      @(posedge core_clk) srst |=> wake_support_mask_reg == 5'h00 && !dsi_reg
                                  && !wake_enable_reg && !wake_status && reg_rdata == 32'h0;
   endproperty
   a_reset_full: assert property (p_reset_full) else $error("field not reset");

   property p_ro_pmcs;
      @(posedge core_clk) disable iff (srst)
         s_pmcs_write |=> pmcs_word[31:16] == 16'h0000 && pmcs_word[14:9] == 6'h00
                          && pmcs_word[7:2] == 6'h00;
   endproperty
   a_ro_pmcs: assert property (p_ro_pmcs) else $error("read-only bit written");

endmodule

// ---- hdl/ppmc_wake.sv ----
// Wake status and wake request gating.
// Assumes event and clear pulses are on core_clk.
`timescale 1ns/1ps
module ppmc_wake (
   input  wire logic core_clk,   // System clock.
   input  wire logic srst,       // Synchronous reset, active high.
   input  wire logic wake_event, // One-cycle wake event.
   input  wire logic clear_st,   // Write-one-to-clear pulse.
   input  wire logic wake_enable,// Enable for the wake request.
   output logic      wake_status,// Sticky wake status.
   output logic      wake_req    // Wake request toward the pin logic.
);

   logic st_reg;

   // Status is sticky; a new event beats a clear in the same cycle.
   // set beats clear
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_reg <= 1'b0;
      end else if (wake_event) begin
         st_reg <= 1'b1;
      end else if (clear_st) begin
         st_reg <= 1'b0;
      end
   end

   assign wake_status = st_reg;
   assign wake_req    = st_reg & wake_enable;

   property p_st_set;
      @(posedge core_clk) disable iff (srst) wake_event |=> st_reg;
   endproperty
   a_st_set: assert property (p_st_set) else $error("status not set");

   property p_req_en;
      @(posedge core_clk) disable iff (srst) wake_req |-> wake_enable && st_reg;
   endproperty
   a_req_en: assert property (p_req_en) else $error("request without enable");

endmodule
